// *** logic/enc_index_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: register indices are word indices; byte address is four times
// Notes: included by the index latch block and its package users
`ifndef ENC_INDEX_CONSTS_SVH
`define ENC_INDEX_CONSTS_SVH

// ****************************************
// register indices
// ****************************************
`define IDX_ENCODER_CONFIG 8'h07
`define IDX_INTERNAL_ACTUAL_POSITION 8'h21
`define IDX_INTERNAL_POSITION_LATCH 8'h36
`define IDX_ENCODER_POSITION_COUNTER 8'h50
`define IDX_ENCODER_CLEAR_VALUE_AND_LATCH 8'h51
`define IDX_REVOLUTION_COUNT 8'h60

// ****************************************
// encoder_config fields
// ****************************************
`define CFG_POL_A 0
`define CFG_POL_B 1
`define CFG_POL_N 2
`define CFG_SKIP_QUAD 3
`define CFG_SENS_LO 4
`define CFG_SENS_HI 5
`define CFG_CLEAR_ON_N 6
`define CFG_CONT 7
`define CFG_ONCE 8
`define CFG_LATCH_ENC 9
`define CFG_LATCH_X 10
`define CFG_MT_EN 11
`define CFG_MT_SIGNED 12
`define CFG_CALC_MT 13
`define CFG_SERIAL_MODE 14
`define CFG_RESET 32'h0000_0000

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 50
`define SCLK_HALF_NS 500
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_PERIOD_NS)

`endif

// *** logic/enc_index_pkg.sv ***
// Purpose: types shared by the index latch block
// Assumes: constants come from enc_index_consts.svh
// Notes: sensitivity encoding matches the two-bit config field
package enc_index_pkg;
    typedef enum logic [1:0] {
        SENS_LEVEL = 2'b00,
        SENS_TO_ACTIVE = 2'b01,
        SENS_TO_INACTIVE = 2'b10,
        SENS_BOTH = 2'b11
    } sens_t;
    typedef logic [31:0] word_t;
endpackage

// *** logic/encoder_index_event_latch.sv ***
// Purpose: index event, clear and latch logic plus multiturn tracking
// Assumes: one 20 MHz clock, APB slave, pins asynchronous to clock
// Notes: quadrature counting arrives as count_step/count_dir pulses
//
// Summary of operation
// - index low active until polarity bit set
// - level mode: event while index is active
// - edge modes: to active, to inactive, both
// - A and B must match their polarity bits
// - skip-qualify bit ignores A and B levels
// - continuous clear loads programmed value every event
// - once mode acts once, then clears once bit
// - clear target is any programmed microstep value
// - latch encoder position on qualifying events
// - also latch internal position when both enabled
// - multiturn input off at reset, unsigned count
// - signed option reads revolutions as two's complement
// - internal calculation tracks singleturn angle wraps
// - device drives serial clock toward the encoder
// - index marks one point per revolution
`timescale 1ns/1ps
`include "enc_index_consts.svh"

module encoder_index_event_latch #(
    parameter int ST_W = 16,
    parameter int MT_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire enc_index_pkg::word_t pwdata,
    output enc_index_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic index_pin,
    input wire logic chan_a_pin,
    input wire logic chan_b_pin,
    input wire logic count_step,
    input wire logic count_dir,
    input wire logic angle_valid,
    input wire logic [ST_W-1:0] angle_in,
    input wire logic [MT_W-1:0] revs_in,
    output logic serial_clk,
    output logic index_event
);
    import enc_index_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic idx_m_ff, idx_s_ff, idx_p_ff;
    logic a_m_ff, a_s_ff, b_m_ff, b_s_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            idx_m_ff <= 1'b1;
            idx_s_ff <= 1'b1;
            idx_p_ff <= 1'b1;
            a_m_ff <= 1'b0;
            a_s_ff <= 1'b0;
            b_m_ff <= 1'b0;
            b_s_ff <= 1'b0;
        end else begin
            idx_m_ff <= index_pin;
            idx_s_ff <= idx_m_ff;
            idx_p_ff <= idx_s_ff;
            a_m_ff <= chan_a_pin;
            a_s_ff <= a_m_ff;
            b_m_ff <= chan_b_pin;
            b_s_ff <= b_m_ff;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    word_t cfg_ff, nxt_cfg;
    word_t x_act_ff, nxt_x_act;
    word_t x_latch_ff, nxt_x_latch;
    word_t enc_pos_ff, nxt_enc_pos;
    word_t clear_val_ff, nxt_clear_val;
    word_t enc_latch_ff, nxt_enc_latch;
    word_t rev_ff, nxt_rev;
    logic [ST_W-1:0] prev_angle_ff, nxt_prev_angle;
    word_t prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic event_ff, nxt_event;
    logic sclk_ff, nxt_sclk;
    logic [7:0] sdiv_ff, nxt_sdiv;

    // ****************************************
    // index event
    // ****************************************
    logic idx_active, prev_active, quad_ok, raw_event, n_event, fire;
    sens_t sens;
    logic [7:0] widx;
    logic bus_op, bus_wr, wr_cfg, wr_pos, known, read_only;
    logic [ST_W-1:0] angle_diff;

    assign sens = sens_t'(cfg_ff[`CFG_SENS_HI:`CFG_SENS_LO]);
    assign idx_active = (idx_s_ff == cfg_ff[`CFG_POL_N]);
    assign prev_active = (idx_p_ff == cfg_ff[`CFG_POL_N]);
    assign quad_ok = cfg_ff[`CFG_SKIP_QUAD] |
        ((a_s_ff == cfg_ff[`CFG_POL_A]) &&
         (b_s_ff == cfg_ff[`CFG_POL_B]));

    always_comb begin
        case (sens)
            SENS_LEVEL: raw_event = idx_active;
            SENS_TO_ACTIVE: raw_event = idx_active & ~prev_active;
            SENS_TO_INACTIVE: raw_event = ~idx_active & prev_active;
            SENS_BOTH: raw_event = idx_active ^ prev_active;
            default: raw_event = 1'b0;
        endcase
    end

    // one point per turn drives clear and snapshots
    assign n_event = raw_event & quad_ok;
    assign fire = n_event & (cfg_ff[`CFG_CONT] | cfg_ff[`CFG_ONCE]);

    // ****************************************
    // apb decode
    // ****************************************
    assign widx = paddr[9:2];
    assign bus_op = psel & penable & ~pready_ff;
    // writes land only at the edge where pready is seen high
    assign bus_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign wr_cfg = bus_wr && (widx == `IDX_ENCODER_CONFIG);
    assign wr_pos = bus_wr && (widx == `IDX_ENCODER_POSITION_COUNTER);
    assign angle_diff = angle_in - prev_angle_ff;

    always_comb begin
        known = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
        read_only = 1'b0;
        nxt_prdata = 32'h0000_0000;
        case (widx)
            `IDX_ENCODER_CONFIG: nxt_prdata = cfg_ff;
            `IDX_INTERNAL_ACTUAL_POSITION: nxt_prdata = x_act_ff;
            `IDX_INTERNAL_POSITION_LATCH: begin
                nxt_prdata = x_latch_ff;
                read_only = 1'b1;
            end
            `IDX_ENCODER_POSITION_COUNTER: nxt_prdata = enc_pos_ff;
            `IDX_ENCODER_CLEAR_VALUE_AND_LATCH: nxt_prdata = enc_latch_ff;
            `IDX_REVOLUTION_COUNT: begin
                nxt_prdata = rev_ff;
                read_only = 1'b1;
            end
            default: known = 1'b0;
        endcase
        if (!known || !bus_op || pwrite) begin
            nxt_prdata = 32'h0000_0000;
        end
        nxt_pready = bus_op;
        nxt_pslverr = bus_op & (~known | (pwrite & read_only));
    end

    // ****************************************
    // next state of the block
    // ****************************************
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_x_act = x_act_ff;
        nxt_x_latch = x_latch_ff;
        nxt_enc_pos = enc_pos_ff;
        nxt_clear_val = clear_val_ff;
        nxt_enc_latch = enc_latch_ff;
        nxt_rev = rev_ff;
        nxt_prev_angle = prev_angle_ff;
        nxt_event = n_event;
        // quadrature counting; decoding lives upstream, the counter itself lives here
        if (count_step) begin
            nxt_enc_pos = count_dir ? enc_pos_ff - 32'h0000_0001
                                    : enc_pos_ff + 32'h0000_0001;
        end
        if (fire) begin
            if (cfg_ff[`CFG_CLEAR_ON_N]) begin
                nxt_enc_pos = clear_val_ff;
            end
            if (cfg_ff[`CFG_LATCH_ENC]) begin
                // old counter value, taken before the clear lands
                nxt_enc_latch = enc_pos_ff;
                if (cfg_ff[`CFG_LATCH_X]) begin
                    nxt_x_latch = x_act_ff;
                end
            end
            if (!cfg_ff[`CFG_CONT]) begin
                nxt_cfg[`CFG_ONCE] = 1'b0;
            end
        end
        if (angle_valid) begin
            nxt_prev_angle = angle_in;
            if (cfg_ff[`CFG_MT_EN]) begin
                if (cfg_ff[`CFG_MT_SIGNED]) begin
                    nxt_rev = {{(32-MT_W){revs_in[MT_W-1]}},
                        revs_in};
                end else begin
                    nxt_rev = {{(32-MT_W){1'b0}}, revs_in};
                end
            end else if (cfg_ff[`CFG_CALC_MT]) begin
                // only sound while steps stay below half a turn
                if (prev_angle_ff[ST_W-1] && !angle_in[ST_W-1] &&
                    !angle_diff[ST_W-1]) begin
                    nxt_rev = rev_ff + 32'h0000_0001;
                end else if (!prev_angle_ff[ST_W-1] && angle_in[ST_W-1] &&
                    angle_diff[ST_W-1]) begin
                    nxt_rev = rev_ff - 32'h0000_0001;
                end
            end
        end
        // a software write wins over any hardware update the same edge
        if (wr_cfg) begin
            nxt_cfg = pwdata;
        end
        if (bus_wr && widx == `IDX_INTERNAL_ACTUAL_POSITION) begin
            nxt_x_act = pwdata;
        end
        if (wr_pos) begin
            nxt_enc_pos = pwdata;
        end
        if (bus_wr && widx == `IDX_ENCODER_CLEAR_VALUE_AND_LATCH) begin
            nxt_clear_val = pwdata;
        end
        // serial clock idles high; toggles only in serial mode
        nxt_sdiv = sdiv_ff;
        nxt_sclk = 1'b1;
        if (cfg_ff[`CFG_SERIAL_MODE]) begin
            nxt_sclk = sclk_ff;
            if (sdiv_ff == 8'(`SCLK_HALF_CYC - 1)) begin
                nxt_sdiv = 8'h00;
                nxt_sclk = ~sclk_ff;
            end else begin
                nxt_sdiv = sdiv_ff + 8'h01;
            end
        end else begin
            nxt_sdiv = 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_ff <= `CFG_RESET;
            x_act_ff <= 32'h0000_0000;
            x_latch_ff <= 32'h0000_0000;
            enc_pos_ff <= 32'h0000_0000;
            clear_val_ff <= 32'h0000_0000;
            enc_latch_ff <= 32'h0000_0000;
            rev_ff <= 32'h0000_0000;
            prev_angle_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            event_ff <= 1'b0;
            sclk_ff <= 1'b1;
            sdiv_ff <= 8'h00;
        end else begin
            cfg_ff <= nxt_cfg;
            x_act_ff <= nxt_x_act;
            x_latch_ff <= nxt_x_latch;
            enc_pos_ff <= nxt_enc_pos;
            clear_val_ff <= nxt_clear_val;
            enc_latch_ff <= nxt_enc_latch;
            rev_ff <= nxt_rev;
            prev_angle_ff <= nxt_prev_angle;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            event_ff <= nxt_event;
            sclk_ff <= nxt_sclk;
            sdiv_ff <= nxt_sdiv;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign serial_clk = sclk_ff;
    assign index_event = event_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    pol_reset_a: assert property ($fell(rst) |->
        !cfg_ff[`CFG_POL_N] && !cfg_ff[`CFG_MT_EN])
        else $error("index polarity or multiturn not cleared by reset");
    level_event_a: assert property (sens == SENS_LEVEL && quad_ok &&
        idx_s_ff == cfg_ff[`CFG_POL_N] |=> index_event)
        else $error("level event missing");
    rise_event_a: assert property (sens == SENS_TO_ACTIVE &&
        n_event |-> idx_active && !prev_active ##1 !n_event)
        else $error("edge event not single on activation");
    quad_qual_a: assert property (n_event &&
        !cfg_ff[`CFG_SKIP_QUAD] |-> a_s_ff == cfg_ff[`CFG_POL_A] &&
        b_s_ff == cfg_ff[`CFG_POL_B])
        else $error("event without A/B qualification");
    skip_qual_a: assert property (cfg_ff[`CFG_SKIP_QUAD] && raw_event
        |-> n_event)
        else $error("A/B levels blocked event while skipped");
    cont_clear_a: assert property (n_event &&
        cfg_ff[`CFG_CLEAR_ON_N] && cfg_ff[`CFG_CONT] && !wr_pos
        |=> enc_pos_ff == $past(clear_val_ff))
        else $error("clear value not loaded");
    once_drop_a: assert property (fire && !cfg_ff[`CFG_CONT] && !wr_cfg
        |=> !cfg_ff[`CFG_ONCE] ##1 (!fire || cfg_ff[`CFG_ONCE]))
        else $error("once bit not dropped");
    enc_latch_a: assert property (fire && cfg_ff[`CFG_LATCH_ENC] |=>
        enc_latch_ff == $past(enc_pos_ff))
        else $error("encoder latch did not take prior count");
    x_latch_a: assert property (fire && cfg_ff[`CFG_LATCH_ENC] &&
        cfg_ff[`CFG_LATCH_X] |=> x_latch_ff == $past(x_act_ff))
        else $error("internal position not latched");
    wrap_fwd_a: assert property (angle_valid &&
        !cfg_ff[`CFG_MT_EN] && cfg_ff[`CFG_CALC_MT] && prev_angle_ff[ST_W-1] &&
        !angle_in[ST_W-1] && !angle_diff[ST_W-1]
        |=> rev_ff == $past(rev_ff) + 32'h0000_0001)
        else $error("forward wrap not counted");
    sclk_idle_a: assert property (!cfg_ff[`CFG_SERIAL_MODE] |=>
        serial_clk)
        else $error("serial clock not idle high");
endmodule

// *** test/enc_partner.sv ***
// Purpose: encoder stand-in driving index, channel and angle pins
// Assumes: bench calls the tasks; every change lands on a rising edge
// Notes: angle lines show inverted data once the valid pulse is gone
`timescale 1ns/1ps

module enc_partner (
    input wire logic clock,
    output logic index_pin,
    output logic chan_a_pin,
    output logic chan_b_pin,
    output logic count_step,
    output logic count_dir,
    output logic angle_valid,
    output logic [15:0] angle_in,
    output logic [15:0] revs_in
);
    initial begin
        index_pin = 1'b1;
        chan_a_pin = 1'b0;
        chan_b_pin = 1'b0;
        count_step = 1'b0;
        count_dir = 1'b0;
        angle_valid = 1'b0;
        angle_in = 16'h0000;
        revs_in = 16'h0000;
    end

    task automatic pins(input logic n, input logic a, input logic b);
        @(posedge clock);
        index_pin <= n;
        chan_a_pin <= a;
        chan_b_pin <= b;
    endtask

    task automatic steps(input int n, input logic d);
        repeat (n) begin
            @(posedge clock);
            count_step <= 1'b1;
            count_dir <= d;
            @(posedge clock);
            count_step <= 1'b0;
        end
    endtask

    // callers move the angle by under half a turn per sample
    task automatic angle(input logic [15:0] a, input logic [15:0] r);
        @(posedge clock);
        angle_valid <= 1'b1;
        angle_in <= a;
        revs_in <= r;
        @(posedge clock);
        angle_valid <= 1'b0;
        angle_in <= ~a;
        revs_in <= ~r;
    endtask
endmodule

// *** test/encoder_index_event_latch_test.sv ***
// Purpose: self-checking bench for the index event and latch block
// Assumes: APB master here, encoder stand-in in enc_partner
// Notes: seeded random qualify and latch values, fixed corner cases
`timescale 1ns/1ps
`include "enc_index_consts.svh"

module encoder_index_event_latch_test;
    import enc_index_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    word_t pwdata = 32'h0000_0000;
    word_t prdata, rd, cv, pv, xv;
    logic pready, pslverr, serial_clk, index_event, err;
    logic index_pin, chan_a_pin, chan_b_pin, count_step, count_dir;
    logic angle_valid;
    logic [15:0] angle_in, revs_in;
    logic [15:0] ang [5] = '{16'h4000, 16'h8000, 16'hc000, 16'h2000,
        16'he000};
    int miscompares = 0, n_compared = 0, cnt, r;
    integer seed = 32'h51fc;

    always #25 clock = ~clock;

    encoder_index_event_latch u_dut (.clock(clock), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .index_pin(index_pin), .chan_a_pin(chan_a_pin),
        .chan_b_pin(chan_b_pin), .count_step(count_step),
        .count_dir(count_dir), .angle_valid(angle_valid),
        .angle_in(angle_in), .revs_in(revs_in), .serial_clk(serial_clk),
        .index_event(index_event));

    enc_partner u_enc (.clock(clock), .index_pin(index_pin),
        .chan_a_pin(chan_a_pin), .chan_b_pin(chan_b_pin),
        .count_step(count_step), .count_dir(count_dir),
        .angle_valid(angle_valid), .angle_in(angle_in), .revs_in(revs_in));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input word_t seen, input word_t exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] idx, input word_t d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input word_t d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input string name, input logic [7:0] idx,
        input word_t exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(name, rd, exp);
    endtask

    task automatic win(output int c);
        c = 0;
        repeat (6) begin
            @(posedge clock);
            if (index_event === 1'b1) c++;
        end
    endtask

    task automatic pulse;
        u_enc.pins(1'b1, 1'b0, 1'b0);
        repeat (6) @(posedge clock);
        u_enc.pins(1'b0, 1'b0, 1'b0);
        repeat (6) @(posedge clock);
    endtask

    function automatic word_t exp_cnt(input logic [1:0] s, input logic act);
        return (s == 2'b11 || s == {~act, act}) ? 32'h0000_0001
                                                : 32'h0000_0000;
    endfunction

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rdc("config", `IDX_ENCODER_CONFIG, `CFG_RESET);
        chk("sclk idle", {31'b0, serial_clk}, 32'h0000_0001);
        apb(1'b0, 8'h7f, 32'h0000_0000);
        chk("unmapped", {31'b0, err}, 32'h1);
        wr(`IDX_INTERNAL_POSITION_LATCH, 32'h1234_5678);
        chk("ro write", {31'b0, err}, 32'h1);
        for (int k = 0; k < 8; k++) begin
            u_enc.pins(~k[2], 1'b0, 1'b0);
            wr(`IDX_ENCODER_CONFIG, {26'b0, k[1:0], 1'b0, k[2], 2'b00});
            repeat (6) @(posedge clock);
            for (int p = 1; p >= 0; p--) begin
                u_enc.pins(p[0] ~^ k[2], 1'b0, 1'b0);
                win(cnt);
                if (k[1:0] == 2'b00) begin
                    chk("level", {31'b0, index_event}, p);
                end else begin
                    chk("edge", cnt,
                        exp_cnt(k[1:0], p[0]));
                end
            end
        end
        for (int k = 0; k < 12; k++) begin
            r = $random(seed);
            u_enc.pins(1'b0, r[0], r[1]);
            wr(`IDX_ENCODER_CONFIG, {26'b0, 2'b01, r[4], 1'b1, r[3:2]});
            repeat (6) @(posedge clock);
            u_enc.pins(1'b1, r[0], r[1]);
            win(cnt);
            chk("qualify", cnt,
                {31'b0, r[4] | (r[1:0] == r[3:2])});
        end
        cv = $random(seed);
        pv = $random(seed);
        xv = $random(seed);
        u_enc.pins(1'b0, 1'b0, 1'b0);
        wr(`IDX_ENCODER_CLEAR_VALUE_AND_LATCH, cv);
        wr(`IDX_ENCODER_POSITION_COUNTER, pv);
        wr(`IDX_INTERNAL_ACTUAL_POSITION, xv);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_06d4);
        pulse();
        rdc("enc latch", `IDX_ENCODER_CLEAR_VALUE_AND_LATCH,
            pv);
        rdc("x latch", `IDX_INTERNAL_POSITION_LATCH, xv);
        rdc("cleared", `IDX_ENCODER_POSITION_COUNTER,
            cv);
        u_enc.steps(3, 1'b0);
        pulse();
        rdc("latch again", `IDX_ENCODER_CLEAR_VALUE_AND_LATCH,
            cv + 3);
        rdc("cleared again", `IDX_ENCODER_POSITION_COUNTER, cv);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_0354);
        pulse();
        rdc("once bit", `IDX_ENCODER_CONFIG, 32'h0000_0254);
        u_enc.steps(2, 1'b1);
        pulse();
        rdc("once only", `IDX_ENCODER_POSITION_COUNTER, cv - 2);
        rdc("latch held", `IDX_ENCODER_CLEAR_VALUE_AND_LATCH, cv);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_2000);
        for (int k = 0; k < 4; k++) u_enc.angle(ang[k], 16'h0000);
        rdc("wrap fwd", `IDX_REVOLUTION_COUNT, 32'h0000_0001);
        u_enc.angle(ang[4], 16'h0000);
        rdc("wrap back", `IDX_REVOLUTION_COUNT, 32'h0000_0000);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_0800);
        u_enc.angle(16'h1000, 16'hfffe);
        rdc("mt unsigned", `IDX_REVOLUTION_COUNT, 32'h0000_fffe);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_1800);
        u_enc.angle(16'h1000, 16'hfffe);
        rdc("mt signed", `IDX_REVOLUTION_COUNT, 32'hffff_fffe);
        wr(`IDX_ENCODER_CONFIG, 32'h0000_4000);
        repeat (20) @(posedge clock);
        cnt = 0;
        r = serial_clk;
        repeat (40) begin
            @(posedge clock);
            if (serial_clk !== r[0]) cnt++;
            r = serial_clk;
        end
        chk("sclk toggles", cnt, 32'h0000_0004);
        report_and_stop();
    end

    // whole run is under a thousand cycles; this 40,000-cycle margin is generous
    initial begin
        #2_000_000;
        miscompares++;
        report_and_stop();
    end
endmodule
